// ### verilog/rrs_pkg.sv
// constants shared by the rotate / fill execution block
// Summary of operation
// - carry rotate: old carry to bit seven
// - decode 0011 00da; update carry, negative, zero
// - destination bit 0 to working, 1 file
// - bank bit 0 access region, 1 bank select
// - plain rotate: bank bit 0 overrides bank
// - extended set, bank 0, address <=95: indexed
// - decode 0100 00da; bit zero to top, N Z
// - decode 0110 100a; write all ones, no flags
`default_nettype none
package rrs_pkg;
  localparam logic [3:0] OPC_RRC_HI   = 4'h3;    // upper nibble of carry rotate
  localparam logic [3:0] OPC_RRP_HI   = 4'h4;    // upper nibble of plain rotate
  localparam logic [3:0] OPC_FILL_HI  = 4'h6;    // upper nibble of fill
  localparam logic [1:0] OPC_ROT_SUB  = 2'h0;    // bits 11:10 of both rotates
  localparam logic [2:0] OPC_FILL_SUB = 3'h4;    // bits 11:9 of fill
  localparam int         DEST_BIT     = 9;       // destination select position
  localparam int         BANK_BIT     = 8;       // bank select position
  localparam logic [7:0] INDEX_LIMIT  = 8'h5F;   // highest indexed offset
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;   // access region low/high split
  localparam logic [3:0] ACCESS_HIGH  = 4'hF;    // bank holding the upper access half
  localparam logic [7:0] FILL_VALUE   = 8'hFF;   // value written by fill
  typedef enum logic [1:0] {PH_DECODE, PH_READ, PH_PROCESS, PH_WRITE} rrs_phase_t;
  typedef enum logic [1:0] {OP_NONE, OP_RRC, OP_RRP, OP_FILL} rrs_op_t;
endpackage
`default_nettype wire

// ### verilog/rrs_phase_gen.sv
// four-phase instruction cycle sequencer
`default_nettype none
module rrs_phase_gen
  import rrs_pkg::*;
(
  input  wire logic       clk,     // core clock
  input  wire logic       rst_n,   // synchronous reset, active low
  output rrs_pkg::rrs_phase_t phase    // current phase
);
  rrs_phase_t ph_r;  // phase register
  // phases advance once per clock, wrapping after write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ph_r <= PH_DECODE;
    end else begin
      case (ph_r)
        PH_DECODE:  ph_r <= PH_READ;
        PH_READ:    ph_r <= PH_PROCESS;
        PH_PROCESS: ph_r <= PH_WRITE;
        default:    ph_r <= PH_DECODE;
      endcase
    end
  end
  assign phase = ph_r;
endmodule
`default_nettype wire

// ### verilog/rrs_exec.sv
// execution datapath for carry rotate, plain rotate and fill-ones
`default_nettype none
module rrs_exec
  import rrs_pkg::*;
(
  input  wire logic        clk,          // core clock
  input  wire logic        rst_n,        // synchronous reset, active low
  input  wire logic [15:0] instr,        // program word, sampled in decode
  input  wire logic        ext_set_en,   // extended instruction set enabled
  input  wire logic [3:0]  bank_select_register, // current bank
  input  wire logic [11:0] index_base,   // indexed literal offset base pointer
  input  wire logic [7:0]  file_rdata,   // file register read data
  input  wire logic        carry_in,     // current carry flag
  output rrs_pkg::rrs_phase_t phase,     // current phase
  output logic             busy_op,      // a handled opcode is in flight
  output logic             file_re,      // file read strobe
  output logic [11:0]      file_addr,    // resolved file address
  output logic             file_we,      // file write strobe
  output logic [7:0]       file_wdata,   // file write data
  output logic             wreg_we,      // working register write strobe
  output logic [7:0]       wreg_wdata,   // working register write data
  output logic             carry_we,     // carry update strobe
  output logic             carry_out,    // new carry
  output logic             nz_we,        // negative/zero update strobe
  output logic             neg_out,      // new negative flag
  output logic             zero_out      // new zero flag
);
  import rrs_pkg::*;

  // decode helper shared by decode and the checks
  function automatic rrs_op_t decode_op(input logic [15:0] w);
    if (w[15:12] == OPC_RRC_HI && w[11:10] == OPC_ROT_SUB) return OP_RRC;
    if (w[15:12] == OPC_RRP_HI && w[11:10] == OPC_ROT_SUB) return OP_RRP;
    if (w[15:12] == OPC_FILL_HI && w[11:9] == OPC_FILL_SUB) return OP_FILL;
    return OP_NONE;
  endfunction

  rrs_op_t     op_r;       // latched operation
  logic        dest_r;     // latched destination bit
  logic [11:0] addr_r;     // latched resolved address
  logic [7:0]  opnd_r;     // operand read in phase two
  logic [7:0]  res_r;      // result formed in phase three
  logic        cy_r;       // carry result
  rrs_op_t     op_dec;     // decode of incoming word
  logic [11:0] addr_dec;   // address resolution of incoming word
  logic        idx_mode;   // indexed literal offset active
  logic [7:0]  f_field;    // file address field
  logic [7:0]  rot_res;    // rotate result selection
  logic        is_wr;      // write phase of a handled op

  rrs_phase_gen u_phase (
    .clk   (clk),
    .rst_n (rst_n),
    .phase (phase)
  );

  assign op_dec   = decode_op(instr);
  assign f_field  = instr[7:0];
  assign idx_mode = ext_set_en && !instr[BANK_BIT] && (f_field <= INDEX_LIMIT);
  // bank bit 0: access region, or indexed when ext_set_en and offset <= INDEX_LIMIT, either overriding the bank select; 1: bank select
  assign addr_dec = idx_mode ? (index_base + {4'h0, f_field}) :
                    instr[BANK_BIT] ? {bank_select_register, f_field} :
                    (f_field < ACCESS_SPLIT) ? {4'h0, f_field} : {ACCESS_HIGH, f_field};

  // latch decode results in phase one
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      op_r   <= OP_NONE;
      dest_r <= 1'b0;
      addr_r <= 12'h000;
    end else if (phase == PH_DECODE) begin
      op_r   <= op_dec;
      dest_r <= instr[DEST_BIT];
      addr_r <= addr_dec;
    end
  end

  // read the operand in phase two
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      opnd_r <= 8'h00;
    end else if (phase == PH_READ) begin
      opnd_r <= file_rdata;
    end
  end

  // rotate selection: carry path or bit-zero wrap
  assign rot_res = (op_r == OP_RRC) ? {carry_in, opnd_r[7:1]} :
                   (op_r == OP_RRP) ? {opnd_r[0], opnd_r[7:1]} :
                   FILL_VALUE;

  // process in phase three
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      res_r <= 8'h00;
      cy_r  <= 1'b0;
    end else if (phase == PH_PROCESS) begin
      res_r <= rot_res;
      cy_r  <= opnd_r[0];
    end
  end

  assign busy_op    = (op_r != OP_NONE);
  assign is_wr      = (phase == PH_WRITE) && busy_op;
  assign file_re    = (phase == PH_READ) && busy_op;
  assign file_addr  = addr_r;
  // fill always writes the file; rotates follow the destination bit
  assign file_we    = is_wr && ((op_r == OP_FILL) || dest_r);
  assign wreg_we    = is_wr && (op_r != OP_FILL) && !dest_r;
  assign file_wdata = res_r;
  assign wreg_wdata = res_r;
  assign carry_we   = is_wr && (op_r == OP_RRC);
  assign carry_out  = cy_r;
  assign nz_we      = is_wr && (op_r != OP_FILL);
  assign neg_out    = res_r[7];
  assign zero_out   = (res_r == 8'h00);

  a_fill_flags: assert property (@(posedge clk) disable iff (!rst_n)
    (op_r == OP_FILL) |-> (!carry_we && !nz_we && !wreg_we)) else $error("fill touched flags");
  a_plain_carry: assert property (@(posedge clk) disable iff (!rst_n)
    (op_r == OP_RRP) |-> !carry_we) else $error("plain rotate wrote carry");
  a_dest_choice: assert property (@(posedge clk) disable iff (!rst_n)
    !(file_we && wreg_we)) else $error("both destinations written");
  a_rrc_value: assert property (@(posedge clk) disable iff (!rst_n)
    (phase == PH_PROCESS && op_r == OP_RRC) |=> (res_r == {$past(carry_in), $past(opnd_r[7:1])}))
    else $error("carry rotate result wrong");
  a_rrp_value: assert property (@(posedge clk) disable iff (!rst_n)
    (phase == PH_PROCESS && op_r == OP_RRP) |=> (res_r[7] == $past(opnd_r[0])))
    else $error("plain rotate wrap wrong");
  a_fill_value: assert property (@(posedge clk) disable iff (!rst_n)
    file_we && op_r == OP_FILL |-> file_wdata == FILL_VALUE) else $error("fill value wrong");
  a_bank_addr: assert property (@(posedge clk) disable iff (!rst_n)
    (phase == PH_DECODE && op_dec != OP_NONE && instr[BANK_BIT]) |=> (addr_r[7:0] == $past(f_field)))
    else $error("bank address wrong");
  a_index_addr: assert property (@(posedge clk) disable iff (!rst_n)
    (phase == PH_DECODE && idx_mode) |=> (addr_r == $past(index_base) + {4'h0, $past(f_field)}))
    else $error("indexed address wrong");
  a_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
    (phase == PH_DECODE && op_dec != OP_NONE) |-> ##3 (file_we || wreg_we)) else $error("no write in phase four");

  // ------------------------------------------------------------------
  // instruction cycle walk, built from named steps
  // ------------------------------------------------------------------

  // a handled opcode is present while the sequencer is in decode
  sequence s_handled_decode;
    (phase == PH_DECODE) && (op_dec != OP_NONE);
  endsequence

  // operand fetch: read strobe raised in the second phase
  sequence s_operand_read;
    (phase == PH_READ) && file_re;
  endsequence

  // process phase: no strobe of any kind yet
  sequence s_quiet_process;
    (phase == PH_PROCESS) && !file_re && !file_we && !wreg_we && !carry_we && !nz_we;
  endsequence

  // destination write in the fourth phase
  sequence s_dest_write;
    is_wr && (file_we || wreg_we);
  endsequence

  // a handled word walks read, process and write on consecutive cycles
  a_phase_walk: assert property (@(posedge clk) disable iff (!rst_n)
    s_handled_decode |-> ##1 s_operand_read ##1 s_quiet_process ##1 s_dest_write)
    else $error("instruction cycle walk broken");

  // the sequencer always returns to decode after the write phase
  a_phase_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    (phase == PH_WRITE) |=> (phase == PH_DECODE))
    else $error("phase did not wrap to decode");

  // write strobes appear only in the write phase
  a_strobe_window: assert property (@(posedge clk) disable iff (!rst_n)
    (phase != PH_WRITE) |-> !(file_we || wreg_we || carry_we || nz_we))
    else $error("strobe outside write phase");

  // an opcode that is not ours leaves the file and flags alone
  a_none_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    (op_r == OP_NONE) |-> !(file_re || file_we || wreg_we || carry_we || nz_we))
    else $error("unhandled opcode raised a strobe");

  // ------------------------------------------------------------------
  // flag and destination checks per operation
  // ------------------------------------------------------------------

  // carry rotate updates carry, negative and zero together
  a_rrc_flags: assert property (@(posedge clk) disable iff (!rst_n)
    (is_wr && op_r == OP_RRC) |-> (carry_we && nz_we))
    else $error("carry rotate flags not updated");

  // the carry rotate hands old bit zero to the carry
  a_rrc_carry: assert property (@(posedge clk) disable iff (!rst_n)
    (phase == PH_PROCESS && op_r == OP_RRC) |=> (cy_r == $past(opnd_r[0])))
    else $error("carry rotate carry wrong");

  // plain rotate updates negative and zero only
  a_rrp_flags: assert property (@(posedge clk) disable iff (!rst_n)
    (is_wr && op_r == OP_RRP) |-> (nz_we && !carry_we))
    else $error("plain rotate flag set wrong");

  // plain rotate keeps the upper seven bits shifted down
  a_rrp_shift: assert property (@(posedge clk) disable iff (!rst_n)
    (phase == PH_PROCESS && op_r == OP_RRP) |=> (res_r[6:0] == $past(opnd_r[7:1])))
    else $error("plain rotate shift wrong");

  // rotates write exactly the destination chosen by the destination bit
  a_rot_dest: assert property (@(posedge clk) disable iff (!rst_n)
    (is_wr && op_r != OP_FILL) |-> ((file_we == dest_r) && (wreg_we == !dest_r)))
    else $error("rotate destination wrong");

  // fill always lands in the file register
  a_fill_dest: assert property (@(posedge clk) disable iff (!rst_n)
    (is_wr && op_r == OP_FILL) |-> file_we)
    else $error("fill did not write the file");

  // ------------------------------------------------------------------
  // address resolution
  // ------------------------------------------------------------------

  // bank bit set: the upper address nibble is the current bank
  a_bank_upper: assert property (@(posedge clk) disable iff (!rst_n)
    (phase == PH_DECODE && instr[BANK_BIT]) |=> (addr_r[11:8] == $past(bank_select_register)))
    else $error("bank nibble wrong");

  // bank bit clear outside indexed mode: access region, bank select ignored
  a_access_addr: assert property (@(posedge clk) disable iff (!rst_n)
    (phase == PH_DECODE && !instr[BANK_BIT] && !idx_mode) |=>
      (addr_r[11:8] == ($past(f_field[7]) ? ACCESS_HIGH : 4'h0)))
    else $error("access region address wrong");

  // indexed mode never applies with the bank bit set
  a_index_gate: assert property (@(posedge clk) disable iff (!rst_n)
    idx_mode |-> (ext_set_en && !instr[BANK_BIT] && (f_field <= INDEX_LIMIT)))
    else $error("indexed mode outside its window");
endmodule
`default_nettype wire

// ### test/rrs_file_model.sv
// file register model answering reads from the execution block
`default_nettype none
module rrs_file_model (
  input  wire logic        clk,        // core clock
  input  wire logic        file_re,    // read strobe
  input  wire logic [11:0] file_addr,  // resolved address
  output logic      [7:0]  file_rdata  // read data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] last_r;  // last value handed out
  // contents follow the address; between reads the bus shows the inverse of the last value
  assign file_rdata = file_re ? (file_addr[7:0] ^ {2{file_addr[11:8]}}) : ~last_r;
  // remember what was read
  always_ff @(posedge clk) begin
    if (file_re) last_r <= file_rdata;
  end
endmodule
`default_nettype wire

// ### test/rrs_exec_test.sv
// self-checking bench for the rotate / fill execution block
`default_nettype none
module rrs_exec_test;
  timeunit 1ns;
  timeprecision 1ns;
  import rrs_pkg::*;
  logic clk = 0, rst_n = 0, ext_set_en = 0, carry_in = 0, d, a;
  logic [15:0] instr = 16'h0;
  logic [3:0] bank_select_register = 4'h0;
  logic [11:0] index_base = 12'h0, file_addr, x;
  logic [7:0] file_rdata, file_wdata, wreg_wdata, f, rd, r;
  logic [7:0] cf [5] = '{8'h00, 8'h5F, 8'h60, 8'h7F, 8'h80};  // address corners
  logic file_re, file_we, wreg_we, carry_we, carry_out, nz_we, neg_out, zero_out, busy_op;
  rrs_phase_t phase;
  int fails = 0, n_tests = 0, seed = 32'h3d8d416e, i, op;
  rrs_exec dut (.clk(clk), .rst_n(rst_n), .instr(instr), .ext_set_en(ext_set_en),
    .bank_select_register(bank_select_register), .index_base(index_base), .file_rdata(file_rdata),
    .carry_in(carry_in), .phase(phase), .busy_op(busy_op), .file_re(file_re), .file_addr(file_addr),
    .file_we(file_we), .file_wdata(file_wdata), .wreg_we(wreg_we), .wreg_wdata(wreg_wdata),
    .carry_we(carry_we), .carry_out(carry_out), .nz_we(nz_we), .neg_out(neg_out), .zero_out(zero_out));
  rrs_file_model fm (.clk(clk), .file_re(file_re), .file_addr(file_addr), .file_rdata(file_rdata));
  // expected resolved address
  function automatic logic [11:0] ea(logic a, logic [7:0] f);
    if (a) return {bank_select_register, f};
    if (ext_set_en && f <= 8'h5F) return index_base + {4'h0, f};
    return {(f[7] ? 4'hF : 4'h0), f};
  endfunction
  // compare and count
  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic summarize;
    $display("fails %0d n_tests %0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // clock, 40 ns period
  initial begin
    forever #20 clk = ~clk;
  end
  // watchdog
  initial begin
    #200000;
    fails++;
    summarize();
  end
  // random instructions with address corners first
  initial begin
    repeat (4) @(posedge clk);
    #1 rst_n = 1;
    for (i = 0; i < 200; i++) begin
      while (phase !== PH_DECODE) begin @(posedge clk); #1; end
      op = $random(seed) & 3;
      {d, a, f, ext_set_en, carry_in} = $random(seed);
      bank_select_register = $random(seed);
      index_base = $random(seed);
      if (i < 5) begin op = i % 3; a = 0; f = cf[i]; ext_set_en = (i == 1 || i == 2); end
      case (op)
        0: instr = {4'h3, 2'h0, d, a, f};
        1: instr = {4'h4, 2'h0, d, a, f};
        2: instr = {4'h6, 3'h4, a, f};
        default: instr = {4'h3, 2'h1, d, a, f};
      endcase
      @(posedge clk); #1 instr = $random(seed);
      x = ea(a, f);
      rd = x[7:0] ^ {2{x[11:8]}};
      r = (op == 0) ? {carry_in, rd[7:1]} : (op == 1) ? {rd[0], rd[7:1]} : 8'hFF;
      chk(phase, PH_READ);
      chk(busy_op, op != 3);
      if (op < 2) chk(file_re, 1'b1);
      if (op != 3) chk(file_addr, x);
      repeat (2) @(posedge clk);
      #1 chk(phase, PH_WRITE);
      chk(file_we, op == 2 || (op < 2 && d));
      chk(wreg_we, op < 2 && !d);
      chk(carry_we, op == 0);
      chk(nz_we, op < 2);
      if (op == 0) chk(carry_out, rd[0]);
      if (op < 2) chk({neg_out, zero_out}, {r[7], r == 8'h00});
      if (op != 3) chk((op < 2 && !d) ? wreg_wdata : file_wdata, r);
    end
    summarize();
  end
endmodule
`default_nettype wire
